// ### verilog/lpm_wake_source_config.sv
// wake source configuration registers, serial slave and low-power wake logic
`timescale 1ns/10ps
// How it works
// (RL1) disabled channel change never wakes device
// (RL2) enabled channel change wakes from low power
// (RL3) host writes accepted anytime in normal mode
// (RL4) all wake enables read one after reset
// (RL5) all enables zero stops polling timer
// (RL6) programmable enables at 0x10, bits 7..0
// (RL7) ground enables at 0x11, bits 13..0
// (RL8) comparator-only channels wake without polling current
// (RL9) comparator-only at 0x12, resets to zero
// (RL10) comparator-only meant for driven logic inputs
// (RL11) current sources pulse once per polling period
// (RL12) frame: address, rw flag, 24 data bits
module lpm_wake_source_config #(
  parameter int POLL_PERIOD_CYCLES = lpm_wake_pkg::POLL_PERIOD_CYC,
  parameter int POLL_ACTIVE_CYCLES = lpm_wake_pkg::POLL_ACTIVE_CYC
) (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        SCLK_IN,
  input  wire logic        CS_N_IN,
  input  wire logic        MOSI_IN,
  output logic             MISO_OUT,
  output logic             MISO_OE_OUT,
  input  wire logic        LOW_POWER_STATE_IN,
  input  wire logic [7:0]  PROG_SW_IN,
  input  wire logic [13:0] GND_SW_IN,
  input  wire logic        FAULT_SUMMARY_IN,
  input  wire logic        PENDING_INTERRUPT_FLAG_IN,
  output logic             WAKE_OUT,
  output logic [21:0]      POLL_CURRENT_OUT
);
  lpm_wake_pkg::state_t r;
  lpm_wake_pkg::state_t n;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        run;
  logic        active;
  logic        sample;
  logic        hit;
  logic [21:0] en_mask;
  logic [21:0] cmp_mask;
  logic [21:0] diff;
  logic [21:0] rdata;

  // register read mux, unused bits zero
  always_comb
  begin
    case (r.last_addr)
      lpm_wake_pkg::ADDR_PROG_WAKE_EN: rdata = {14'h0000, r.wen_p}; // RL6
      lpm_wake_pkg::ADDR_GND_WAKE_EN:  rdata = {8'h00, r.wen_g};    // RL7
      lpm_wake_pkg::ADDR_PROG_CMP:     rdata = {14'h0000, r.cmp_p}; // RL9
      default:                         rdata = 22'h000000;
    endcase
  end

  // serial edge detection on filtered pins
  always_comb
  begin
    sclk_rise = (r.sclk_s[1] == r.sclk_s[2]) && r.sclk_s[2] && !r.sclk_f;
    sclk_fall = (r.sclk_s[1] == r.sclk_s[2]) && !r.sclk_s[2] && r.sclk_f;
    cs_fall   = (r.cs_s[1] == r.cs_s[2]) && !r.cs_s[2] && r.cs_f;
    cs_rise   = (r.cs_s[1] == r.cs_s[2]) && r.cs_s[2] && !r.cs_f;
  end

  // polling timer and change detection
  always_comb
  begin
    en_mask  = {r.wen_g, r.wen_p};
    cmp_mask = {14'h0000, r.cmp_p};
    diff     = r.sw_f ^ r.ref_sw;
    run      = LOW_POWER_STATE_IN && r.lpm_d && (|en_mask);                // RL5
    active   = run && (r.poll_cnt < 32'(POLL_ACTIVE_CYCLES));               // RL11
    sample   = run && (r.poll_cnt == 32'(POLL_ACTIVE_CYCLES - 1));
    hit      = (|(diff & en_mask & cmp_mask))                               // RL8
               || (sample && (|(diff & en_mask & ~cmp_mask)));              // RL1 RL2
  end

  // next state
  always_comb
  begin
    n        = r;
    n.sclk_s = {r.sclk_s[1:0], SCLK_IN};
    n.cs_s   = {r.cs_s[1:0], CS_N_IN};
    n.mosi_s = {r.mosi_s[1:0], MOSI_IN};
    n.sw1    = {GND_SW_IN, PROG_SW_IN};
    n.sw2    = r.sw1;
    n.sw3    = r.sw2;
    if (r.sclk_s[1] == r.sclk_s[2])
      n.sclk_f = r.sclk_s[2];
    if (r.cs_s[1] == r.cs_s[2])
      n.cs_f = r.cs_s[2];
    for (int i = 0; i < lpm_wake_pkg::ALL_CH; i++)
    begin
      if (r.sw2[i] == r.sw3[i])
        n.sw_f[i] = r.sw3[i];
    end
    // frame start: load reply to previous command
    if (cs_fall)
    begin
      n.tx      = {r.last_addr, r.last_rw, FAULT_SUMMARY_IN, PENDING_INTERRUPT_FLAG_IN, rdata}; // RL12
      n.miso    = r.last_addr[6];
      n.miso_oe = 1'b1;
      n.cnt     = 6'h00;
    end
    else if (!r.cs_f && sclk_rise)
    begin
      n.rx = {r.rx[30:0], r.mosi_s[2]};
      if (r.cnt != 6'h3F)
        n.cnt = r.cnt + 6'h01;
    end
    else if (!r.cs_f && sclk_fall)
    begin
      n.tx   = {r.tx[30:0], 1'b0};
      n.miso = r.tx[30];
    end
    else if (cs_rise)
    begin
      n.miso    = 1'b0;
      n.miso_oe = 1'b0;
      if (r.cnt == lpm_wake_pkg::FRAME_BITS_W)
      begin
        n.last_addr = r.rx[lpm_wake_pkg::ADDR_MSB:lpm_wake_pkg::ADDR_LSB]; // RL12
        n.last_rw   = r.rx[lpm_wake_pkg::RW_BIT];
        // writes land only in normal mode
        if (r.rx[lpm_wake_pkg::RW_BIT] && !LOW_POWER_STATE_IN)        // RL3
        begin
          case (r.rx[lpm_wake_pkg::ADDR_MSB:lpm_wake_pkg::ADDR_LSB])
            lpm_wake_pkg::ADDR_PROG_WAKE_EN: n.wen_p = r.rx[7:0];       // RL6
            lpm_wake_pkg::ADDR_GND_WAKE_EN:  n.wen_g = r.rx[13:0];      // RL7
            lpm_wake_pkg::ADDR_PROG_CMP:     n.cmp_p = r.rx[7:0];       // RL9
            default:                         n.cnt   = r.cnt;
          endcase
        end
      end
    end
    // low-power entry snapshot and wake latch
    n.lpm_d = LOW_POWER_STATE_IN;
    if (!LOW_POWER_STATE_IN)
      n.wake = 1'b0;
    else if (!r.lpm_d)
    begin
      n.ref_sw = r.sw_f;
      n.wake   = 1'b0;
    end
    else if (hit)
      n.wake = 1'b1;                                                    // RL2
    // polling period counter, held at zero when stopped
    if (!run)
      n.poll_cnt = 32'h00000000;                                        // RL5
    else if (r.poll_cnt == 32'(POLL_PERIOD_CYCLES - 1))
      n.poll_cnt = 32'h00000000;
    else
      n.poll_cnt = r.poll_cnt + 32'h00000001;
    n.poll_cur = active ? ~cmp_mask : 22'h000000;                       // RL8 RL11
  end

  // state register
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      r          <= '0;
      r.sclk_f   <= 1'b0;
      r.cs_s     <= 3'h7;
      r.cs_f     <= 1'b1;
      r.wen_p    <= lpm_wake_pkg::PROG_WAKE_EN_RST;                     // RL4
      r.wen_g    <= lpm_wake_pkg::GND_WAKE_EN_RST;                      // RL4
      r.cmp_p    <= lpm_wake_pkg::PROG_CMP_RST;                         // RL9
    end
    else
      r <= n;
  end

  // outputs straight from flops
  assign MISO_OUT         = r.miso;
  assign MISO_OE_OUT      = r.miso_oe;
  assign WAKE_OUT         = r.wake;
  assign POLL_CURRENT_OUT = r.poll_cur;

  // checks

  // enables come out of reset at their defaults
  a_reset_enables: assert property (@(posedge CLK_IN) // RL4
    $rose(RESET_N_IN) |-> r.wen_p == 8'hFF && r.wen_g == 14'h3FFF && r.cmp_p == 8'h00)
    else $error("enables not all one after reset");

  // nothing enabled, nothing wakes
  a_no_wake_disabled: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL1
    (en_mask == 22'h000000 && r.lpm_d && !r.wake) |=> !r.wake)
    else $error("wake with every enable cleared");

  // changes on disabled channels only never wake
  a_disabled_change: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL1
    (LOW_POWER_STATE_IN && r.lpm_d && !r.wake && (diff & en_mask) == 22'h000000) |=> !r.wake)
    else $error("disabled channel woke the block");

  // reference taken on low-power entry
  a_snapshot_on_entry: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL1
    (LOW_POWER_STATE_IN && !r.lpm_d) |=> r.ref_sw == $past(r.sw_f))
    else $error("switch reference not taken on entry");

  // comparator-only change wakes next cycle
  a_cmp_wake_now: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL2
    (LOW_POWER_STATE_IN && r.lpm_d && |(diff & en_mask & cmp_mask)) |=> r.wake)
    else $error("comparator-only change did not wake");

  // polled change wakes at the sample point
  a_poll_wake: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL2
    (sample && |(diff & en_mask & ~cmp_mask)) |=> r.wake)
    else $error("polled change did not wake");

  // wake drops once back in normal mode
  a_wake_clears: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL2
    !LOW_POWER_STATE_IN |=> !r.wake)
    else $error("wake held in normal mode");

  // timer parked with every enable cleared
  a_poll_stopped: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL5
    (en_mask == 22'h000000) |=> r.poll_cnt == 32'h00000000 && r.poll_cur == 22'h000000)
    else $error("polling timer runs with no enables");

  // current pulse at period start
  a_poll_pulse: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL11
    (run && r.poll_cnt == 32'h00000000 && r.cmp_p == 8'h00) |=> r.poll_cur == 22'h3FFFFF)
    else $error("no current pulse at period start");

  // current off after the active time
  a_poll_idle: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL11
    (run && r.poll_cnt >= 32'(POLL_ACTIVE_CYCLES)) |=> r.poll_cur == 22'h000000)
    else $error("current on outside active time");

  // period counter stays in range
  a_poll_wraps: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL11
    r.poll_cnt < 32'(POLL_PERIOD_CYCLES))
    else $error("polling counter out of range");

  // no polling current on comparator-only channels
  a_cmp_no_current: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL8
    ##1 (r.poll_cur & {14'h0000, $past(r.cmp_p)}) == 22'h000000)
    else $error("polling current on comparator-only channel");

  // programmable enable write lands in normal mode
  a_write_taken: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL3
    (cs_rise && r.cnt == 6'h20 && r.rx[31:24] == 8'h21 && !LOW_POWER_STATE_IN)
    |=> r.wen_p == $past(r.rx[7:0]))
    else $error("wake enable write lost");

  // ground enable write lands in normal mode
  a_gnd_write_taken: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL7
    (cs_rise && r.cnt == 6'h20 && r.rx[31:24] == 8'h23 && !LOW_POWER_STATE_IN)
    |=> r.wen_g == $past(r.rx[13:0]))
    else $error("ground enable write lost");

  // comparator-only write lands in normal mode
  a_cmp_write_taken: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL9
    (cs_rise && r.cnt == 6'h20 && r.rx[31:24] == 8'h25 && !LOW_POWER_STATE_IN)
    |=> r.cmp_p == $past(r.rx[7:0]))
    else $error("comparator-only write lost");

  // writes in low power leave registers alone
  a_lp_write_refused: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL3
    (cs_rise && r.cnt == 6'h20 && r.rx[24] && LOW_POWER_STATE_IN)
    |=> $stable(r.wen_p) && $stable(r.wen_g) && $stable(r.cmp_p))
    else $error("write taken in low power");

  // registers stand between writes
  a_enable_hold: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL3
    !(cs_rise && r.cnt == 6'h20 && r.rx[24]) |=> $stable(r.wen_p) && $stable(r.wen_g) && $stable(r.cmp_p))
    else $error("register changed without a write");

  // unused reply bits read zero
  a_unused_zero: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL6
    cs_fall |=> r.tx[21:14] == 8'h00)
    else $error("unused reply bits not zero");

  // reply carries programmable enables
  a_reply_prog_data: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL6
    (cs_fall && r.last_addr == lpm_wake_pkg::ADDR_PROG_WAKE_EN) |=> r.tx[21:0] == {14'h0000, $past(r.wen_p)})
    else $error("programmable enable reply wrong");

  // reply carries ground enables
  a_reply_gnd_data: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL7
    (cs_fall && r.last_addr == lpm_wake_pkg::ADDR_GND_WAKE_EN) |=> r.tx[21:0] == {8'h00, $past(r.wen_g)})
    else $error("ground enable reply wrong");

  // reply carries comparator-only bits
  a_reply_cmp_data: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL9
    (cs_fall && r.last_addr == lpm_wake_pkg::ADDR_PROG_CMP) |=> r.tx[21:0] == {14'h0000, $past(r.cmp_p)})
    else $error("comparator-only reply wrong");

  // reply header echoes the last command
  a_frame_header: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL12
    cs_fall |=> r.tx[31:25] == $past(r.last_addr) && r.miso_oe)
    else $error("reply header wrong");

  // output enable follows the filtered select
  a_oe_in_frame: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL12
    r.miso_oe == !r.cs_f)
    else $error("data out enable not tied to select");

  // data out low while deselected
  a_miso_idle_low: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // RL12
    r.cs_f |-> !r.miso)
    else $error("data out not low while deselected");

  // main scenarios
  c_write_frame: cover property (@(posedge CLK_IN) cs_rise && r.cnt == 6'h20 && r.rx[24]);
  c_wake_poll:   cover property (@(posedge CLK_IN) sample && hit);
  c_wake_cmp:    cover property (@(posedge CLK_IN) $rose(r.wake) && |r.cmp_p);
  c_lp_write:    cover property (@(posedge CLK_IN) cs_rise && r.cnt == 6'h20 && r.rx[24] && LOW_POWER_STATE_IN);
  c_poll_stop:   cover property (@(posedge CLK_IN) LOW_POWER_STATE_IN && r.lpm_d && en_mask == 22'h000000);
endmodule : lpm_wake_source_config

// ### shared/lpm_wake_pkg.sv
// constants and state layout for the wake source configuration block
package lpm_wake_pkg;
  // register addresses (7-bit)
  localparam logic [6:0]  ADDR_PROG_WAKE_EN = 7'h10;
  localparam logic [6:0]  ADDR_GND_WAKE_EN  = 7'h11;
  localparam logic [6:0]  ADDR_PROG_CMP     = 7'h12;
  // values after reset
  localparam logic [7:0]  PROG_WAKE_EN_RST  = 8'hFF;
  localparam logic [13:0] GND_WAKE_EN_RST   = 14'h3FFF;
  localparam logic [7:0]  PROG_CMP_RST      = 8'h00;
  // frame layout
  localparam int FRAME_BITS   = 32;
  localparam int ADDR_MSB     = 31;
  localparam int ADDR_LSB     = 25;
  localparam int RW_BIT       = 24;
  localparam int FAULT_BIT    = 23;
  localparam int PENDING_INTERRUPT_FLAG_BIT   = 22;
  localparam logic [5:0] FRAME_BITS_W = 6'h20;
  // channel counts
  localparam int PROG_CH = 8;
  localparam int GND_CH  = 14;
  localparam int ALL_CH  = 22;
  // polling timing
  localparam int CLK_MHZ          = 100;
  localparam int POLL_PERIOD_MS   = 64;
  localparam int POLL_PERIOD_CYC  = POLL_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int POLL_ACTIVE_NS   = 1000;
  localparam int POLL_ACTIVE_CYC  = (POLL_ACTIVE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [2:0]  mosi_s;
    logic        sclk_f;
    logic        cs_f;
    logic [21:0] sw1;
    logic [21:0] sw2;
    logic [21:0] sw3;
    logic [21:0] sw_f;
    logic [31:0] rx;
    logic [5:0]  cnt;
    logic [31:0] tx;
    logic [6:0]  last_addr;
    logic        last_rw;
    logic        miso;
    logic        miso_oe;
    logic [7:0]  wen_p;
    logic [13:0] wen_g;
    logic [7:0]  cmp_p;
    logic        lpm_d;
    logic [21:0] ref_sw;
    logic [31:0] poll_cnt;
    logic        wake;
    logic [21:0] poll_cur;
  } state_t;
endpackage : lpm_wake_pkg

// ### test/spi_host_model.sv
// serial host model that sends 32-bit frames into the block
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out
);
  // idle levels: clock low, deselected
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // one frame msb first, six core cycles per phase
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    repeat (6) @(posedge clk_in);
    cs_n_out <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      repeat (6) @(posedge clk_in);
      mosi_out <= tx[i];
      repeat (6) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      rx[i] = miso_in;
      @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (6) @(posedge clk_in);
    cs_n_out <= 1'b1;
    mosi_out <= ~tx[0]; // released line shows no stale bit
  endtask : frame
endmodule : spi_host_model

// ### test/lpm_wake_source_config_test.sv
// self-checking bench for the wake source configuration block
`timescale 1ns/10ps
module lpm_wake_source_config_test;
  localparam int PERIOD = 50;
  localparam int ACTIVE = 4;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        oe;
  logic        lp = 1'b0;
  logic [7:0]  prog_sw = 8'h00;
  logic [13:0] gnd_sw = 14'h0000;
  logic        fault = 1'b0;
  logic        pending_interrupt_flag = 1'b0;
  logic        wake;
  logic [21:0] poll_cur;
  logic [31:0] seed = 32'h00000022;
  logic [31:0] d;
  int          errors = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;

  lpm_wake_source_config #(.POLL_PERIOD_CYCLES(PERIOD), .POLL_ACTIVE_CYCLES(ACTIVE)) u_lpm_wake_source_config (
    .CLK_IN(clk), .RESET_N_IN(reset_n), .SCLK_IN(sclk), .CS_N_IN(cs_n), .MOSI_IN(mosi),
    .MISO_OUT(miso), .MISO_OE_OUT(oe), .LOW_POWER_STATE_IN(lp), .PROG_SW_IN(prog_sw),
    .GND_SW_IN(gnd_sw), .FAULT_SUMMARY_IN(fault), .PENDING_INTERRUPT_FLAG_IN(pending_interrupt_flag),
    .WAKE_OUT(wake), .POLL_CURRENT_OUT(poll_cur));

  spi_host_model u_spi_host_model (.clk_in(clk), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi));

  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // write frame
  task automatic wr(input logic [6:0] a, input logic [23:0] v);
    logic [31:0] r;
    u_spi_host_model.frame({a, 1'b1, v}, r);
  endtask : wr

  // read twice, reply of the first shows in the second
  task automatic rd(input logic [6:0] a, input logic [23:0] v);
    logic [31:0] r;
    d = rnd();
    @(posedge clk);
    {fault, pending_interrupt_flag} <= d[1:0];
    u_spi_host_model.frame({a, 25'h0000000}, r);
    u_spi_host_model.frame({a, 25'h0000000}, r);
    check("reply", r, {a, 1'b0, d[1:0], v[21:0]});
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("miso_idle", {30'h00000000, oe, miso}, 32'h00000000);
  endtask : rd

  // configure, sleep, measure polling, toggle switches, look at wake
  task automatic lp_run(input logic [7:0] wp, input logic [13:0] wg, input logic [7:0] cm,
                        input logic [21:0] tog, input logic ex, input int w);
    int hits;
    wr(7'h10, {16'h0000, wp});
    wr(7'h11, {10'h000, wg});
    wr(7'h12, {16'h0000, cm});
    d = rnd();
    @(posedge clk);
    {gnd_sw, prog_sw} <= d[21:0];
    repeat (10) @(posedge clk);
    lp <= 1'b1;
    hits = 0;
    repeat (10) @(posedge clk);
    repeat (2 * PERIOD)
    begin
      @(negedge clk);
      if (poll_cur === {14'h3FFF, ~cm})
        hits++;
    end
    check("poll", 32'(hits), ((wp | wg) != 0) ? 32'(2 * ACTIVE) : 32'h0);
    @(posedge clk);
    {gnd_sw, prog_sw} <= {gnd_sw, prog_sw} ^ tog;
    repeat (w) @(posedge clk);
    @(negedge clk);
    check("wake", wake, ex);
    @(posedge clk);
    lp <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("wake_clr", wake, 1'b0);
  endtask : lp_run

  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(7'h10, 24'h0000FF);
    rd(7'h11, 24'h003FFF);
    rd(7'h12, 24'h000000);
    wr(7'h13, 24'hFFFFFF);
    rd(7'h13, 24'h000000);
    for (int k = 0; k < 3; k++)
    begin
      d = rnd();
      wr(7'h10 + 7'(k), d[23:0]);
      rd(7'h10 + 7'(k), d[23:0] & ((k == 1) ? 24'h003FFF : 24'h0000FF));
    end
    lp_run(8'h01, 14'h0000, 8'h01, 22'h3FFFFE, 1'b0, 2 * PERIOD);
    lp_run(8'h01, 14'h0000, 8'h01, 22'h000001, 1'b1, 12);
    lp_run(8'h00, 14'h0001, 8'h00, 22'h000100, 1'b1, PERIOD + 12);
    lp_run(8'h00, 14'h0000, 8'h00, 22'h3FFFFF, 1'b0, 2 * PERIOD);
    // write in low power must be dropped
    @(posedge clk);
    lp <= 1'b1;
    wr(7'h10, 24'h0000A5);
    repeat (6) @(posedge clk);
    lp <= 1'b0;
    rd(7'h10, 24'h000000);
    conclude();
  end

  // watchdog, about five times the expected run
  initial
  begin
    #1000000;
    errors++;
    conclude();
  end
endmodule : lpm_wake_source_config_test
